// *** hw/spimsb_port.sv ***
// Byte-wide serial port, master or slave, with Wishbone register slave.
// Assumes all pin inputs are asynchronous to CLOCK; they are synchronised
// here. Pin output enables are active low.
`timescale 1ns/10ps

module spimsb_port (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [4:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic PORT_IRQ,
  input wire logic SEL_N_I,
  output logic SEL_N_O,
  output logic SEL_N_OE_N,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_N,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE_N,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE_N
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_two_q;
  logic [7:0] baud_q;
  logic [7:0] match_q;
  logic [7:0] tx_buf_q;
  logic tx_full_q;
  logic [7:0] rx_buf_q;
  logic rx_full_q;
  logic match_flag_q;
  logic fault_flag_q;
  logic fault_armed_q;
  logic tx_armed_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [1:0] sel_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] mosi_sync_q;
  logic [1:0] miso_sync_q;
  logic sck_prev_q;
  spimsb_pkg::spimsb_state_e state_q;
  logic [7:0] sh_q;
  logic sh_full_q;
  logic latch_q;
  logic [4:0] edge_q;
  logic [11:0] div_q;
  logic sck_lvl_q;
  logic [15:0] cfg_q;

  logic port_en;
  logic master;
  logic phase;
  logic lsb_first;
  logic single_wire;
  logic sw_out;
  logic fault_en;
  logic sel_out_en;
  logic acc;
  logic wr;
  logic rd;
  logic wr_data;
  logic wr_c1;
  logic [11:0] half;
  logic tick;
  logic sel_low;
  logic slave_edge;
  logic ev;
  logic [4:0] edge_n;
  logic odd;
  logic sample_ev;
  logic shift_ev;
  logic done;
  logic din;
  logic dout;
  logic [7:0] sh_next;
  logic fault;
  logic cfg_change;
  logic abort;
  logic load;
  logic [15:0] cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Shift one bit into the shifter at the end chosen by bit order.
  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic b,
                                          input logic lsbf);
    shift_in = lsbf ? {b, s[7:1]} : {s[6:0], b};
  endfunction : shift_in

  // Half a serial clock period in bus clocks.
  function automatic logic [11:0] half_period(input logic [7:0] br);
    logic [3:0] r;
    logic [11:0] p;
    r = br[spimsb_pkg::BR_RATE_LO +: 4];
    p = {9'h000, br[spimsb_pkg::BR_PRE_LO +: 3]} + 12'h001;
    if (r > spimsb_pkg::BR_RATE_MAX) begin
      r = spimsb_pkg::BR_RATE_MAX;
    end
    half_period = p << r;
  endfunction : half_period

  ////////////////////////////////////////////////////////////////////////////
  // Control decode.

  assign port_en = ctrl_one_q[spimsb_pkg::C1_PORT_EN];
  assign master = ctrl_one_q[spimsb_pkg::C1_MASTER];
  assign phase = ctrl_one_q[spimsb_pkg::C1_PHASE];
  assign lsb_first = ctrl_one_q[spimsb_pkg::C1_LSB_FIRST];
  assign sel_out_en = ctrl_one_q[spimsb_pkg::C1_SEL_OUT_EN];
  assign single_wire = ctrl_two_q[spimsb_pkg::C2_SINGLE_WIRE];
  assign sw_out = ctrl_two_q[spimsb_pkg::C2_SW_OUT_DIR];
  assign fault_en = ctrl_two_q[spimsb_pkg::C2_FAULT_EN];
  assign half = half_period(baud_q);

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack for one cycle.

  assign acc = WB_CYC_I & WB_STB_I & ack_q;
  assign wr = acc & WB_WE_I & WB_SEL_I[0];
  assign rd = acc & ~WB_WE_I;
  assign wr_data = wr & (WB_ADR_I[4:2] == spimsb_pkg::IDX_DATA);
  assign wr_c1 = wr & (WB_ADR_I[4:2] == spimsb_pkg::IDX_CTRL_ONE);
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= WB_CYC_I & WB_STB_I & ~ack_q;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdat_q <= 32'h0000_0000;
    end else begin
      unique case (WB_ADR_I[4:2])
        spimsb_pkg::IDX_CTRL_ONE: rdat_q <= {24'h000000, ctrl_one_q};
        spimsb_pkg::IDX_CTRL_TWO: rdat_q <= {24'h000000, ctrl_two_q};
        spimsb_pkg::IDX_BAUD: rdat_q <= {24'h000000, baud_q};
        spimsb_pkg::IDX_STATUS: begin
          rdat_q <= {24'h000000, rx_full_q, match_flag_q, ~tx_full_q,
                     fault_flag_q, 4'h0};
        end
        spimsb_pkg::IDX_DATA: rdat_q <= {24'h000000, rx_buf_q};
        spimsb_pkg::IDX_MATCH: rdat_q <= {24'h000000, match_q};
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_one_q <= spimsb_pkg::CTRL_ONE_RST;
    end else if (fault) begin
      ctrl_one_q[spimsb_pkg::C1_MASTER] <= 1'b0;
    end else if (wr_c1) begin
      ctrl_one_q <= WB_DAT_I[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_two_q <= spimsb_pkg::CTRL_TWO_RST;
      baud_q <= spimsb_pkg::BAUD_RST;
      match_q <= spimsb_pkg::MATCH_RST;
    end else if (wr) begin
      if (WB_ADR_I[4:2] == spimsb_pkg::IDX_CTRL_TWO) begin
        ctrl_two_q <= WB_DAT_I[7:0];
      end
      if (WB_ADR_I[4:2] == spimsb_pkg::IDX_BAUD) begin
        baud_q <= WB_DAT_I[7:0];
      end
      if (WB_ADR_I[4:2] == spimsb_pkg::IDX_MATCH) begin
        match_q <= WB_DAT_I[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and its write permission.

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_armed_q <= 1'b0;
    end else if (wr_data) begin
      tx_armed_q <= 1'b0;
    end else if (rd && WB_ADR_I[4:2] == spimsb_pkg::IDX_STATUS) begin
      tx_armed_q <= ~tx_full_q;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_buf_q <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (wr_data && tx_armed_q && !tx_full_q) begin
      tx_buf_q <= WB_DAT_I[7:0];
      tx_full_q <= 1'b1;
    end else if (load || (done && !abort)) begin
      tx_full_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and flags; a hardware set wins over a clear.

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_buf_q <= 8'h00;
      rx_full_q <= 1'b0;
      match_flag_q <= 1'b0;
    end else begin
      if (done && !rx_full_q) begin
        rx_buf_q <= sh_next;
        rx_full_q <= 1'b1;
      end else if (rd && WB_ADR_I[4:2] == spimsb_pkg::IDX_DATA) begin
        rx_full_q <= 1'b0;
      end
      if (done && !rx_full_q && sh_next == match_q) begin
        match_flag_q <= 1'b1;
      end else if (wr && WB_ADR_I[4:2] == spimsb_pkg::IDX_STATUS &&
                   WB_DAT_I[spimsb_pkg::ST_MATCH]) begin
        match_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      fault_flag_q <= 1'b0;
      fault_armed_q <= 1'b0;
    end else if (fault) begin
      fault_flag_q <= 1'b1;
      fault_armed_q <= 1'b0;
    end else if (wr_c1 && fault_armed_q) begin
      fault_flag_q <= 1'b0;
      fault_armed_q <= 1'b0;
    end else if (rd && WB_ADR_I[4:2] == spimsb_pkg::IDX_STATUS &&
                 fault_flag_q) begin
      fault_armed_q <= 1'b1;
    end
  end

  assign PORT_IRQ = fault_flag_q & ctrl_one_q[spimsb_pkg::C1_IRQ_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      mosi_sync_q <= 2'h0;
      miso_sync_q <= 2'h0;
      sck_prev_q <= 1'b0;
    end else begin
      sel_sync_q <= {sel_sync_q[0], SEL_N_I};
      sck_sync_q <= {sck_sync_q[0], SCK_I};
      mosi_sync_q <= {mosi_sync_q[0], MOSI_I};
      miso_sync_q <= {miso_sync_q[0], MISO_I};
      sck_prev_q <= sck_sync_q[1];
    end
  end

  assign sel_low = ~sel_sync_q[1];
  assign fault = port_en & master & fault_en & ~sel_out_en & sel_low;

  ////////////////////////////////////////////////////////////////////////////
  // Engine events.

  assign cfg = {ctrl_one_q[spimsb_pkg::C1_POLARITY], phase, sel_out_en,
                lsb_first, fault_en, single_wire, single_wire & sw_out,
                baud_q, 1'b0};
  assign cfg_change = master & (cfg != cfg_q);
  assign abort = ~port_en | fault | cfg_change |
                 (~master & state_q != spimsb_pkg::SPIMSB_IDLE & ~sel_low);
  assign tick = (div_q == half - 12'h001);
  assign slave_edge = ~master & sel_low &
                      (sck_sync_q[1] != sck_prev_q);
  assign ev = master ? (tick & (state_q == spimsb_pkg::SPIMSB_LEAD |
                                state_q == spimsb_pkg::SPIMSB_CLOCKING))
                     : ((state_q == spimsb_pkg::SPIMSB_CLOCKING) & slave_edge);
  assign edge_n = edge_q + 5'h01;
  assign odd = edge_n[0];
  assign sample_ev = ev & (phase ? ~odd : odd);
  assign shift_ev = ev & (phase ? (odd & edge_n != 5'h01) : ~odd);
  assign done = ev & (edge_n == spimsb_pkg::EDGES_PER_BYTE);
  assign din = master ? (single_wire ? mosi_sync_q[1] : miso_sync_q[1])
                      : (single_wire ? miso_sync_q[1] : mosi_sync_q[1]);
  // With phase set the eighth bit is taken straight from the pin.
  assign sh_next = shift_in(sh_q, (phase && done) ? din : latch_q,
                            lsb_first);
  assign dout = lsb_first ? sh_q[0] : sh_q[7];
  assign load = tx_full_q & ~sh_full_q &
                (state_q == spimsb_pkg::SPIMSB_IDLE);

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_q <= 16'h0000;
    end else begin
      cfg_q <= cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state.

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= spimsb_pkg::SPIMSB_IDLE;
    end else if (abort) begin
      state_q <= spimsb_pkg::SPIMSB_IDLE;
    end else begin
      unique case (state_q)
        spimsb_pkg::SPIMSB_IDLE: begin
          if (master && sh_full_q) begin
            state_q <= spimsb_pkg::SPIMSB_LEAD;
          end else if (!master && sel_low) begin
            state_q <= spimsb_pkg::SPIMSB_CLOCKING;
          end
        end
        spimsb_pkg::SPIMSB_LEAD: begin
          if (tick) begin
            state_q <= spimsb_pkg::SPIMSB_CLOCKING;
          end
        end
        spimsb_pkg::SPIMSB_CLOCKING: begin
          if (done && master) begin
            state_q <= spimsb_pkg::SPIMSB_TAIL;
          end
        end
        spimsb_pkg::SPIMSB_TAIL: begin
          if (tick) begin
            state_q <= spimsb_pkg::SPIMSB_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_q <= 12'h000;
    end else if (state_q == spimsb_pkg::SPIMSB_IDLE || abort || tick) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      edge_q <= 5'h00;
      sck_lvl_q <= 1'b0;
    end else if (abort || done ||
                 (state_q != spimsb_pkg::SPIMSB_CLOCKING && !ev)) begin
      edge_q <= 5'h00;
      sck_lvl_q <= 1'b0;
    end else if (ev) begin
      edge_q <= edge_n;
      sck_lvl_q <= ~sck_lvl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shifter.

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      latch_q <= 1'b0;
    end else if (sample_ev) begin
      latch_q <= din;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sh_q <= 8'h00;
      sh_full_q <= 1'b0;
    end else if (abort) begin
      sh_full_q <= 1'b0;
    end else if (load) begin
      sh_q <= tx_buf_q;
      sh_full_q <= 1'b1;
    end else if (done) begin
      sh_q <= tx_full_q ? tx_buf_q : sh_next;
      sh_full_q <= tx_full_q;
    end else if (shift_ev) begin
      sh_q <= sh_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins.

  always_comb begin
    SEL_N_O = 1'b1;
    SEL_N_OE_N = 1'b1;
    SCK_O = ctrl_one_q[spimsb_pkg::C1_POLARITY];
    SCK_OE_N = 1'b1;
    MOSI_O = dout;
    MOSI_OE_N = 1'b1;
    MISO_O = dout;
    MISO_OE_N = 1'b1;
    if (port_en && master) begin
      SCK_O = ctrl_one_q[spimsb_pkg::C1_POLARITY] ^ sck_lvl_q;
      SCK_OE_N = 1'b0;
      MOSI_OE_N = single_wire & ~sw_out;
      if (fault_en && sel_out_en) begin
        SEL_N_O = (state_q == spimsb_pkg::SPIMSB_IDLE);
        SEL_N_OE_N = 1'b0;
      end
    end else if (port_en && sel_low && !fault_flag_q) begin
      MISO_OE_N = single_wire & ~sw_out;
    end
  end

endmodule : spimsb_port

// *** hw/spimsb_pkg.sv ***
// Constants for the byte-wide serial port: register indices, field
// positions, reset values and transfer counts.
// Assumes a 32-bit classic Wishbone register bus, one word per register.
package spimsb_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [2:0] IDX_CTRL_ONE = 3'h0;
  localparam logic [2:0] IDX_CTRL_TWO = 3'h1;
  localparam logic [2:0] IDX_BAUD = 3'h2;
  localparam logic [2:0] IDX_STATUS = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h5;
  localparam logic [2:0] IDX_MATCH = 3'h7;

  // Control register one fields.
  localparam int C1_LSB_FIRST = 0;
  localparam int C1_SEL_OUT_EN = 1;
  localparam int C1_PHASE = 2;
  localparam int C1_POLARITY = 3;
  localparam int C1_MASTER = 4;
  localparam int C1_PORT_EN = 6;
  localparam int C1_IRQ_EN = 7;

  // Control register two fields.
  localparam int C2_SINGLE_WIRE = 0;
  localparam int C2_SW_OUT_DIR = 3;
  localparam int C2_FAULT_EN = 4;

  // Baud register fields.
  localparam int BR_RATE_LO = 0;
  localparam int BR_PRE_LO = 4;
  localparam logic [3:0] BR_RATE_MAX = 4'h8;

  // Status register fields.
  localparam int ST_FAULT = 4;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_MATCH = 6;
  localparam int ST_RX_FULL = 7;

  // Reset values.
  localparam logic [7:0] CTRL_ONE_RST = 8'h04;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'h00;

  // Serial clock edges per byte.
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

  typedef enum logic [1:0] {
    SPIMSB_IDLE,
    SPIMSB_LEAD,
    SPIMSB_CLOCKING,
    SPIMSB_TAIL
  } spimsb_state_e;

endpackage : spimsb_pkg

// *** verification/spimsb_asserts.sv ***
// Concurrent checks on the pins and register bus of the serial port.
// Assumes it is bound to spimsb_port and sees only that module's ports.
`timescale 1ns/10ps

module spimsb_asserts (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic PORT_IRQ,
  input wire logic SEL_N_I,
  input wire logic SEL_N_O,
  input wire logic SEL_N_OE_N,
  input wire logic SCK_O,
  input wire logic SCK_OE_N,
  input wire logic MOSI_OE_N,
  input wire logic MISO_OE_N
);
  logic sck_q;
  logic [7:0] edge_cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Previous serial clock level.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= SCK_O;
    end
  end

  // Serial clock edges seen while select is low.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      edge_cnt_q <= 8'h00;
    end else if (SEL_N_O) begin
      edge_cnt_q <= 8'h00;
    end else if (SCK_O != sck_q) begin
      edge_cnt_q <= edge_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  AST_ACK_ANSWER: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    && !$past(WB_ACK_O) |=> WB_ACK_O) else $error("ack missing");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  AST_UPPER_ZERO: assert property (WB_ACK_O && !WB_WE_I
    |-> WB_DAT_O[31:8] == 24'h000000) else $error("upper read bits set");
  AST_IRQ_RELEASE: assert property ($rose(PORT_IRQ)
    |-> SCK_OE_N && MOSI_OE_N && MISO_OE_N) else $error("pins not released");
  AST_ONE_DRIVER: assert property (MOSI_OE_N || MISO_OE_N)
    else $error("both data pins driven");
  AST_MASTER_DATA: assert property (!SCK_OE_N |-> MISO_OE_N)
    else $error("master drives slave data pin");
  AST_SLAVE_QUIET: assert property (SCK_OE_N |-> SEL_N_OE_N)
    else $error("select driven without clock");
  AST_DESELECT_HIZ: assert property (SEL_N_I [*4] |-> MISO_OE_N)
    else $error("deselected data output driven");
  AST_IDLE_CLOCK: assert property (!SEL_N_OE_N && SEL_N_O
    && $past(SEL_N_O) && !$past(WB_ACK_O) |-> SCK_O == sck_q)
    else $error("clock moves while idle");
  AST_LEAD_QUIET: assert property ($fell(SEL_N_O) && !SEL_N_OE_N
    |-> SCK_O == sck_q) else $error("clock moves at select");
  AST_EDGE_COUNT: assert property ($rose(SEL_N_O) && !SEL_N_OE_N
    && !$past(WB_ACK_O, 2) |-> edge_cnt_q[3:0] == 4'h0 && edge_cnt_q != 8'h00)
    else $error("byte not sixteen clock edges");

endmodule : spimsb_asserts

// *** verification/spimsb_slave_model.sv ***
// Behavioural serial slave: clock idle low, sample on rising edges,
// shift on falling edges, most significant bit first.
// Assumes it sees the resolved select, clock and data wires.
`timescale 1ns/10ps

module spimsb_slave_model (
  input wire logic sel_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte,
  output logic done
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic last = 1'b0;
  int cnt = 0;

  initial done = 1'b0;
  initial rx_byte = 8'h00;

  always @(negedge sel_n) begin
    sh = tx_byte;
    cnt = 0;
  end

  // Samples the master's data on odd edges.
  always @(posedge sck) begin
    if (!sel_n) begin
      rx = {rx[6:0], mosi};
      cnt++;
      if (cnt == 8) begin
        rx_byte = rx;
        done = ~done;
        cnt = 0;
      end
    end
  end

  always @(negedge sck) begin
    if (!sel_n) begin
      sh = (cnt == 0) ? tx_byte : {sh[6:0], 1'b0};
    end
  end

  always @(sh or sel_n) begin
    if (!sel_n) begin
      last = sh[7];
    end
  end

  // A released line shows the inverse of its last level.
  assign miso = sel_n ? ~last : sh[7];

endmodule : spimsb_slave_model

// *** verification/test_spi_master_slave_byte_port.sv ***
// Self-checking bench for the serial port in master and fault modes.
// Assumes the slave model and checker files are compiled first.
`timescale 1ns/10ps

module test_spi_master_slave_byte_port;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, junk;
  logic ack, irq, sel_n_o, sel_n_oe_n, sck_o, sck_oe_n;
  logic mosi_o, mosi_oe_n, miso_o, miso_oe_n, sel_drv = 1'b1;
  logic sel_w, sck_w, mosi_w, miso_w, slv_miso, slv_done;
  logic [7:0] slv_tx = 8'h00;
  logic [7:0] slv_rx, first, b0, b2;
  logic [31:0] exp_q[$];
  logic [7:0] mq[$];
  logic [7:0] rst_tab[8] = '{8'h04, 0, 0, 8'h20, 0, 0, 0, 0};
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;

  always #2.5 clock = ~clock;

  assign sel_w = sel_n_oe_n ? sel_drv : sel_n_o;
  assign sck_w = sck_oe_n ? 1'b0 : sck_o;
  assign mosi_w = mosi_oe_n ? cycles[0] : mosi_o;
  assign miso_w = miso_oe_n ? slv_miso : miso_o;

  spimsb_port dut (.CLOCK(clock), .RESET_N(reset_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
    .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PORT_IRQ(irq),
    .SEL_N_I(sel_w), .SEL_N_O(sel_n_o), .SEL_N_OE_N(sel_n_oe_n),
    .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_N(sck_oe_n), .MOSI_I(mosi_w),
    .MOSI_O(mosi_o), .MOSI_OE_N(mosi_oe_n), .MISO_I(miso_w),
    .MISO_O(miso_o), .MISO_OE_N(miso_oe_n));

  spimsb_slave_model slave (.sel_n(sel_w), .sck(sck_w), .mosi(mosi_w),
    .tx_byte(slv_tx), .miso(slv_miso), .rx_byte(slv_rx), .done(slv_done));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check

  task automatic wb(input logic w, input logic [2:0] idx, input logic [7:0] d,
                    input logic chk, input logic [7:0] e,
                    output logic [31:0] rd);
    if (chk) exp_q.push_back({24'h0, e});
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    do @(posedge clock); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 1'b0, 8'h00, junk);
  endtask : wr

  task automatic rd_chk(input logic [2:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, 1'b1, e, junk);
  endtask : rd_chk

  task automatic poll(input int b);
    junk = 32'h0;
    for (int i = 0; i < 400 && junk[b] !== 1'b1; i++)
      wb(1'b0, spimsb_pkg::IDX_STATUS, 8'h00, 1'b0, 8'h00, junk);
  endtask : poll

  task automatic gap(output int k);
    logic s;
    s = sck_o;
    k = 0;
    while (sck_o === s && k < 2000) begin
      @(posedge clock);
      k++;
    end
  endtask : gap

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      check(exp_q.pop_front(), dat_o);
  end

  always @(slv_done) begin
    if (mq.size() > 0) check({24'h0, mq.pop_front()}, {24'h0, slv_rx});
    else if (reset_n) check(32'h0, 32'h1);
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    junk = $urandom(32'hc46c40ba);
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(3'(i), rst_tab[i]);
    $display("test reset done");
    b0 = 8'($urandom());
    b2 = 8'($urandom());
    first = 8'($urandom());
    slv_tx = first;
    wr(spimsb_pkg::IDX_CTRL_TWO, 8'h10);
    wr(spimsb_pkg::IDX_BAUD, 8'h11);
    wr(spimsb_pkg::IDX_MATCH, first);
    wr(spimsb_pkg::IDX_CTRL_ONE, 8'h52);
    rd_chk(spimsb_pkg::IDX_STATUS, 8'h20);
    mq.push_back(b0);
    wr(spimsb_pkg::IDX_DATA, b0);
    wr(spimsb_pkg::IDX_DATA, ~b0);
    poll(5);
    mq.push_back(b2);
    wr(spimsb_pkg::IDX_DATA, b2);
    for (int i = 0; i < 2000 && mq.size() > 1; i++) @(posedge clock);
    slv_tx = ~first;
    for (int i = 0; i < 2000 && mq.size() > 0; i++) @(posedge clock);
    for (int i = 0; i < 2000 && sel_n_o !== 1'b1; i++) @(posedge clock);
    rd_chk(spimsb_pkg::IDX_STATUS, 8'he0);
    rd_chk(spimsb_pkg::IDX_DATA, first);
    rd_chk(spimsb_pkg::IDX_STATUS, 8'h60);
    wr(spimsb_pkg::IDX_STATUS, 8'h40);
    rd_chk(spimsb_pkg::IDX_STATUS, 8'h20);
    $display("test master transfer done");
    wr(spimsb_pkg::IDX_CTRL_ONE, 8'hd0);
    sel_drv <= 1'b0;
    repeat (8) @(posedge clock);
    check({31'h0, irq}, 32'h1);
    check({31'h0, sck_oe_n}, 32'h1);
    rd_chk(spimsb_pkg::IDX_CTRL_ONE, 8'hc0);
    rd_chk(spimsb_pkg::IDX_STATUS, 8'h30);
    sel_drv <= 1'b1;
    wr(spimsb_pkg::IDX_CTRL_ONE, 8'h40);
    rd_chk(spimsb_pkg::IDX_STATUS, 8'h20);
    check({31'h0, irq}, 32'h0);
    $display("test mode fault done");
    wr(spimsb_pkg::IDX_CTRL_ONE, 8'h52);
    wr(spimsb_pkg::IDX_BAUD, 8'h12);
    poll(5);
    wr(spimsb_pkg::IDX_DATA, 8'($urandom()));
    for (int i = 0; i < 100 && sel_n_o !== 1'b0; i++) @(posedge clock);
    gap(n);
    check(n, 32'd8);
    gap(n);
    check(n, 32'd8);
    wr(spimsb_pkg::IDX_BAUD, 8'h10);
    repeat (3) @(posedge clock);
    check({31'h0, sel_n_o}, 32'h1);
    repeat (40) @(posedge clock);
    rd_chk(spimsb_pkg::IDX_STATUS, 8'h20);
    $display("test abort done");
    complete_run();
  end

endmodule : test_spi_master_slave_byte_port

bind spimsb_port spimsb_asserts u_chk (.CLOCK(CLOCK), .RESET_N(RESET_N),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PORT_IRQ(PORT_IRQ),
  .SEL_N_I(SEL_N_I), .SEL_N_O(SEL_N_O), .SEL_N_OE_N(SEL_N_OE_N),
  .SCK_O(SCK_O), .SCK_OE_N(SCK_OE_N), .MOSI_OE_N(MOSI_OE_N),
  .MISO_OE_N(MISO_OE_N));
